// file: core/dcc_top.v
// Contract
// RQ1: Two identical comparators, each with own registers.
// RQ2: Negative channel field selects one of four pins.
// RQ3: Positive channel: pin, DAC, fixed ref, ground.
// RQ4: Enable bit 7 switches comparator on.
// RQ5: Result bit reads comparison, inverted by polarity.
// RQ6: Polarity inverts result before bit, pin, edges.
// RQ7: Pin driven whenever pin enable set, ignoring enable.
// RQ8: Speed select resets to one; zero is low-power.
// RQ9: Sync mode updates on timer clock falling edge.
// RQ10: Rise enable sets flag on low-to-high result.
// RQ11: Fall enable sets flag on high-to-low result.
// RQ12: Mirror register holds both results, bits 1-0.
// RQ13: Unimplemented bits ignore writes, read zero.
// RQ14: New edge during flag clear keeps flag set.
// RQ15: Edge detection runs even while comparator disabled.
// RQ16: Internal result registered every cycle.
// RQ17: Raw comparison input, forced low when disabled.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_regs.vh"

module dcc_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [1:0]  raw_compare,
	input  wire        timer_clk,
	output reg  [1:0]  comparator_enable,
	output reg  [1:0]  speed_select,
	output reg  [1:0]  hysteresis_enable,
	output reg  [3:0]  positive_channel_select,
	output reg  [3:0]  negative_channel_select,
	output reg  [1:0]  timer_result,
	output reg  [1:0]  pin_result,
	output reg  [1:0]  pin_result_oe,
	output reg  [1:0]  comparator_edge_flag,
	output reg         irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg  [7:0] ctrl_a_reg [0:1];
	reg  [7:0] ctrl_b_reg [0:1];
	reg  [1:0] result_reg;
	reg  [1:0] result_prev_reg;
	reg  [1:0] hold_reg;
	reg  [1:0] flag_reg;
	reg  [1:0] mask_reg;
	reg        tclk_prev_reg;
	wire [1:0] raw_s;
	wire       tclk_s;

	// Both the raw comparator bits and the timer clock come from outside pclk
	dcc_sync2 #(
		.WIDTH(3)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({timer_clk, raw_compare}),
		.sync_out ({tclk_s, raw_s})
	);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function [7:0] merge_write;
		input [7:0] old_val;
		input [7:0] new_val;
		input [7:0] wmask;
		begin
			merge_write = (old_val & ~wmask) | (new_val & wmask);
		end
	endfunction

	// Polarity applied to the gated comparison
	function polar_result;
		input [7:0] ctrl_a;
		input       raw;
		begin
			polar_result = (raw & ctrl_a[`DCC_A_ENABLE_BIT])
				^ ctrl_a[`DCC_A_INVERT_BIT]; // [RQ5] [RQ6] [RQ17]
		end
	endfunction

	// Result bit is read-only, so it is spliced in on read
	function [7:0] ctrl_a_view;
		input [7:0] ctrl_a;
		input       result;
		begin
			ctrl_a_view = ctrl_a | ({7'h00, result} << `DCC_A_RESULT_BIT);
		end
	endfunction

	// Sync mode takes the value held at the last timer fall
	function route_result;
		input [7:0] ctrl_a;
		input       held;
		input       live;
		begin
			route_result = ctrl_a[`DCC_A_SYNC_BIT] ? held : live; // [RQ9]
		end
	endfunction

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire       wr_access  = psel & penable & pwrite;
	wire       rd_setup   = psel & ~penable & ~pwrite;
	wire       setup      = psel & ~penable;
	wire       hit_a1     = (paddr == `DCC_CTRL_A1_ADDR);
	wire       hit_b1     = (paddr == `DCC_CTRL_B1_ADDR);
	wire       hit_a2     = (paddr == `DCC_CTRL_A2_ADDR);
	wire       hit_b2     = (paddr == `DCC_CTRL_B2_ADDR);
	wire       hit_mirror = (paddr == `DCC_MIRROR_ADDR);
	wire       hit_stat   = (paddr == `DCC_IRQ_STAT_ADDR);
	wire       hit_mask   = (paddr == `DCC_IRQ_MASK_ADDR);
	wire       hit_any    = hit_a1 | hit_b1 | hit_a2 | hit_b2 | hit_mirror | hit_stat | hit_mask;
	reg  [7:0] read_mux;

	always @*
	begin
		read_mux = 8'h00;
		if (hit_a1)
			read_mux = ctrl_a_view(ctrl_a_reg[0], result_reg[0]); // [RQ5]
		else if (hit_b1)
			read_mux = ctrl_b_reg[0]; // [RQ13]
		else if (hit_a2)
			read_mux = ctrl_a_view(ctrl_a_reg[1], result_reg[1]); // [RQ5]
		else if (hit_b2)
			read_mux = ctrl_b_reg[1];
		else if (hit_mirror)
			read_mux = {6'h00, result_reg}; // [RQ12] [RQ13]
		else if (hit_stat)
			read_mux = {6'h00, flag_reg};
		else if (hit_mask)
			read_mux = {6'h00, mask_reg};
	end

	// No wait state: ready answers in the first access cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~hit_any;
			if (rd_setup)
				prdata <= {24'h00_0000, read_mux};
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	integer i;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < 2; i = i + 1)
			begin
				ctrl_a_reg[i] <= `DCC_A_RESET; // [RQ8]
				ctrl_b_reg[i] <= `DCC_B_RESET;
			end
			mask_reg <= `DCC_IRQ_RESET;
		end
		else if (wr_access)
		begin
			// Result bit and unimplemented bits are outside the write masks
			if (hit_a1)
				ctrl_a_reg[0] <= merge_write(ctrl_a_reg[0], pwdata[7:0], `DCC_A_WMASK);
			else if (hit_b1)
				ctrl_b_reg[0] <= merge_write(ctrl_b_reg[0], pwdata[7:0], `DCC_B_WMASK); // [RQ13]
			else if (hit_a2)
				ctrl_a_reg[1] <= merge_write(ctrl_a_reg[1], pwdata[7:0], `DCC_A_WMASK);
			else if (hit_b2)
				ctrl_b_reg[1] <= merge_write(ctrl_b_reg[1], pwdata[7:0], `DCC_B_WMASK);
			else if (hit_mask)
				mask_reg <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// Per-comparator datapath
	// ----------------------------------------
	// Timer clock falling edge, seen on synchronised copy
	wire       tclk_fall = tclk_prev_reg & ~tclk_s; // [RQ9]
	reg  [1:0] polar_now;
	reg  [1:0] rise_evt;
	reg  [1:0] fall_evt;
	reg  [1:0] clr_bits;
	integer    k;

	always @*
	begin
		clr_bits = (wr_access & hit_stat) ? pwdata[1:0] : 2'b00;
		for (k = 0; k < 2; k = k + 1)
		begin
			polar_now[k] = polar_result(ctrl_a_reg[k], raw_s[k]);
			// Edges follow the result even with the comparator off
			rise_evt[k] = result_reg[k] & ~result_prev_reg[k]
				& ctrl_b_reg[k][`DCC_B_RISE_BIT]; // [RQ10] [RQ15]
			fall_evt[k] = ~result_reg[k] & result_prev_reg[k]
				& ctrl_b_reg[k][`DCC_B_FALL_BIT]; // [RQ11] [RQ15]
		end
	end

	// ----------------------------------------
	// Result and edge pipeline
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_reg      <= 2'b00;
			result_prev_reg <= 2'b00;
		end
		else
		begin
			result_reg      <= polar_now; // [RQ16]
			result_prev_reg <= result_reg;
		end
	end

	// ----------------------------------------
	// Timer clock synchronous hold
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_reg      <= 2'b00;
			tclk_prev_reg <= 1'b0;
		end
		else
		begin
			tclk_prev_reg <= tclk_s;
			if (tclk_fall)
				hold_reg <= result_reg; // [RQ9]
		end
	end

	// ----------------------------------------
	// Sticky edge flags
	// ----------------------------------------
	// Set wins over a simultaneous write-one clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_reg <= `DCC_IRQ_RESET;
		else
			flag_reg <= (flag_reg & ~clr_bits) | rise_evt | fall_evt; // [RQ14]
	end

	// ----------------------------------------
	// Configuration outputs
	// ----------------------------------------
	integer m;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			comparator_enable       <= 2'b00;
			speed_select            <= 2'b11;
			hysteresis_enable       <= 2'b00;
			positive_channel_select <= 4'h0;
			negative_channel_select <= 4'h0;
		end
		else
		begin
			for (m = 0; m < 2; m = m + 1)
			begin // [RQ1]
				comparator_enable[m] <= ctrl_a_reg[m][`DCC_A_ENABLE_BIT]; // [RQ4]
				speed_select[m]      <= ctrl_a_reg[m][`DCC_A_SPEED_BIT]; // [RQ8]
				hysteresis_enable[m] <= ctrl_a_reg[m][`DCC_A_HYST_BIT];
				positive_channel_select[2*m +: 2] <=
					ctrl_b_reg[m][`DCC_B_PCH_LSB +: 2]; // [RQ3]
				negative_channel_select[2*m +: 2] <=
					ctrl_b_reg[m][`DCC_B_NCH_LSB +: 2]; // [RQ2]
			end
		end
	end

	// ----------------------------------------
	// Result outputs to timer and pin
	// ----------------------------------------
	integer n;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_result  <= 2'b00;
			pin_result    <= 2'b00;
			pin_result_oe <= 2'b00;
		end
		else
		begin
			for (n = 0; n < 2; n = n + 1)
			begin
				timer_result[n]  <=
					route_result(ctrl_a_reg[n], hold_reg[n], polar_now[n]); // [RQ9]
				pin_result[n]    <=
					route_result(ctrl_a_reg[n], hold_reg[n], polar_now[n]); // [RQ6] [RQ9]
				// Drives regardless of the enable bit
				pin_result_oe[n] <= ctrl_a_reg[n][`DCC_A_PIN_EN_BIT]; // [RQ7]
			end
		end
	end

	// ----------------------------------------
	// Interrupt outputs
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			comparator_edge_flag <= 2'b00;
			irq                  <= 1'b0;
		end
		else
		begin
			comparator_edge_flag <= flag_reg;
			irq                  <= |(flag_reg & mask_reg);
		end
	end

endmodule // dcc_top

`default_nettype wire

// file: core/dcc_regs.vh
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DCC_CTRL_A1_ADDR   12'h000
`define DCC_CTRL_B1_ADDR   12'h004
`define DCC_CTRL_A2_ADDR   12'h008
`define DCC_CTRL_B2_ADDR   12'h00C
`define DCC_MIRROR_ADDR    12'h010
`define DCC_IRQ_STAT_ADDR  12'h014
`define DCC_IRQ_MASK_ADDR  12'h018

// ----------------------------------------
// Control A fields
// ----------------------------------------
`define DCC_A_ENABLE_BIT   7
`define DCC_A_RESULT_BIT   6
`define DCC_A_PIN_EN_BIT   5
`define DCC_A_INVERT_BIT   4
`define DCC_A_SPEED_BIT    2
`define DCC_A_HYST_BIT     1
`define DCC_A_SYNC_BIT     0
`define DCC_A_WMASK        8'hB7
`define DCC_A_RESET        8'h04

// ----------------------------------------
// Control B fields
// ----------------------------------------
`define DCC_B_RISE_BIT     7
`define DCC_B_FALL_BIT     6
`define DCC_B_PCH_LSB      4
`define DCC_B_NCH_LSB      0
`define DCC_B_WMASK        8'hF3
`define DCC_B_RESET        8'h00

// ----------------------------------------
// Channel codes
// ----------------------------------------
`define DCC_PCH_PIN        2'h0
`define DCC_PCH_DAC        2'h1
`define DCC_PCH_FIXED      2'h2
`define DCC_PCH_GROUND     2'h3

`define DCC_IRQ_RESET      2'h0

`endif

// file: core/dcc_sync2.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------
module dcc_sync2 #(
	parameter WIDTH = 4
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // dcc_sync2

`default_nettype wire

// file: test/dcc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_partner (
	input  wire logic       pclk,
	input  wire logic       tmr_run,
	input  wire logic [1:0] raw_set,
	output var  logic [1:0] raw_compare,
	output var  logic       timer_clk
);
	logic [1:0] div_reg;
	initial
	begin
		raw_compare = 2'h0;
		timer_clk = 1'b0;
		div_reg = 2'h0;
	end
	// Timer clock stands low while stopped
	always @(posedge pclk)
	begin
		raw_compare <= raw_set;
		div_reg <= tmr_run ? div_reg + 2'h1 : 2'h0;
		timer_clk <= tmr_run & ((div_reg == 2'h3) ^ timer_clk);
	end
endmodule // dcc_partner
`default_nettype wire

// file: test/dcc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  speed_select,
	input wire logic [1:0]  timer_result,
	input wire logic [1:0]  pin_result,
	input wire logic [1:0]  comparator_edge_flag,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr)
		else $error("unmapped access not refused");
	a_speed_reset: assert property ($rose(presetn) |-> speed_select == 2'h3)
		else $error("speed select not one after reset");
	a_irq_needs_flag: assert property (comparator_edge_flag == 2'h0 |-> !irq)
		else $error("irq without flag");
	a_flag_clear_write: assert property (
		|($past(comparator_edge_flag) & ~comparator_edge_flag)
		|-> $past(psel && penable && pwrite && paddr == 12'h014, 2))
		else $error("flag fell without a write");
	a_pin_timer_match: assert property (pin_result == timer_result)
		else $error("pin and timer result differ");
endmodule // dcc_monitor
bind dcc_top dcc_monitor dcc_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .speed_select, .timer_result, .pin_result,
	.comparator_edge_flag, .irq);
`default_nettype wire

// file: test/dcc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [1:0]  raw_set = 2'h0;
	logic        tmr_run = 1'b0;
	logic [31:0] prdata, rdata;
	logic        pready, pslverr, err, timer_clk, irq;
	logic [1:0]  raw_compare, cen, spd, pres, poe, hys, tres, eflag;
	logic [3:0]  pch, nch;
	int          error_cnt = 0;
	int          tests_run = 0;
	always #50 pclk = ~pclk;
	dcc_partner dcc_partner_inst (.pclk, .tmr_run, .raw_set, .raw_compare, .timer_clk);
	dcc_top dcc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .raw_compare, .timer_clk, .comparator_enable(cen),
		.speed_select(spd), .hysteresis_enable(hys), .positive_channel_select(pch),
		.negative_channel_select(nch), .timer_result(tres), .pin_result(pres),
		.pin_result_oe(poe), .comparator_edge_flag(eflag), .irq);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			results();
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk("prdata", {24'h00_0000, e}, rdata);
	endtask
	task automatic results();
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk("spd", 32'h0000_0003, {30'h0, spd});
		rd(12'h000, 8'h04);
		rd(12'h008, 8'h04);
		rd(12'h010, 8'h00);
		xfer(1'b1, 12'h018, 8'h03);
		xfer(1'b1, 12'h004, 8'hC0);
		raw_set <= 2'h1;
		xfer(1'b1, 12'h000, 8'h80);
		repeat (6) @(posedge pclk);
		rd(12'h000, 8'hC0);
		rd(12'h010, 8'h01);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		chk("eflag", 32'h0000_0001, {30'h0, eflag});
		chk("pin0", 32'h0000_0001, {31'h0, pres[0]});
		chk("tmr0", 32'h0000_0001, {31'h0, tres[0]});
		xfer(1'b1, 12'h014, 8'h01);
		rd(12'h014, 8'h00);
		xfer(1'b1, 12'h000, 8'h90);
		repeat (6) @(posedge pclk);
		rd(12'h000, 8'h90);
		rd(12'h014, 8'h01);
		xfer(1'b1, 12'h014, 8'h01);
		xfer(1'b1, 12'h000, 8'h10);
		repeat (6) @(posedge pclk);
		rd(12'h000, 8'h50);
		rd(12'h014, 8'h01);
		rd(12'h01C, 8'h00);
		chk("slverr", 32'h0000_0001, {31'h0, err});
		xfer(1'b1, 12'h004, 8'hFF);
		rd(12'h004, 8'hF3);
		xfer(1'b1, 12'h010, 8'hFF);
		rd(12'h010, 8'h01);
		xfer(1'b1, 12'h000, 8'h02);
		repeat (2) @(posedge pclk);
		chk("spd", 32'h0000_0002, {30'h0, spd});
		chk("hys", 32'h0000_0001, {30'h0, hys});
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, 12'h00C, {2'h0, i[1:0], 2'h0, i[1:0]});
			repeat (2) @(posedge pclk);
			chk("pch", i, {30'h0, pch[3:2]});
			chk("nch", i, {30'h0, nch[3:2]});
		end
		xfer(1'b1, 12'h008, 8'h21);
		raw_set <= 2'h3;
		repeat (2) @(posedge pclk);
		chk("poe", 32'h0000_0001, {31'h0, poe[1]});
		xfer(1'b1, 12'h008, 8'hA1);
		repeat (8) @(posedge pclk);
		chk("cen", 32'h0000_0002, {30'h0, cen});
		chk("pin", 32'h0000_0000, {31'h0, pres[1]});
		tmr_run <= 1'b1;
		repeat (24) @(posedge pclk);
		chk("pin", 32'h0000_0001, {31'h0, pres[1]});
		chk("tmr1", 32'h0000_0001, {31'h0, tres[1]});
		results();
	end
endmodule // dcc_top_tb_top
`default_nettype wire
